// ==== logic/dsp_defines.svh ====
`ifndef DSP_DEFINES_SVH
`define DSP_DEFINES_SVH

// ref_clk cycles per base clock cycle: one ref_clk cycle is one base half-cycle
`define BASE_HALF_STEPS 2
// shortest serial bit period, in base half-cycles
`define MIN_PERIOD_HALF 10'h002
// msb position of a data word
`define WORD_MSB 3'h7
// one word left in the burst
`define LAST_WORD 8'h01
`define IDX_ZERO 4'h0
`define PHASE_ZERO 10'h000
// header index when the rw bit is sent / suppressed
`define HDR_TWO_BITS 4'h1
`define HDR_ONE_BIT 4'h0
`define BUF_DEPTH 2'h2

`endif

// ==== logic/dsp_pkg.sv ====
package dsp_pkg;

  typedef enum logic [1:0] {
    three_wire = 2'h0,
    four_wire = 2'h1,
    five_wire_clk = 2'h2,
    five_wire_cs = 2'h3
  } serial_variant_t;

  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_pre = 5'h02,
    st_hdr = 5'h04,
    st_data = 5'h08,
    st_gap = 5'h10
  } frame_state_t;

  // one access request
  typedef struct packed {
    logic read;
    logic rs;
    logic [7:0] words;
  } access_cmd_t;

  // one write word with its register select
  typedef struct packed {
    logic rs;
    logic [7:0] data;
  } write_word_t;

  // all serial timing settings, in ns
  typedef struct packed {
    logic [7:0] base_clock_period_value;
    logic [7:0] write_clock_period_setting;
    logic [7:0] write_clock_fall_setting;
    logic [7:0] write_clock_rise_setting;
    logic [7:0] read_clock_period_setting;
    logic [7:0] read_clock_fall_setting;
    logic [7:0] read_clock_rise_setting;
    logic [7:0] read_sample_point_setting;
  } timing_cfg_t;

endpackage

// ==== logic/word_skid_buffer.sv ====
`timescale 1ns/1ps
`include "dsp_defines.svh"

module word_skid_buffer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire dsp_pkg::write_word_t in_word,
  input wire logic in_valid,
  output logic in_ready,
  output dsp_pkg::write_word_t out_word,
  output logic out_valid,
  input wire logic out_ready
);
  dsp_pkg::write_word_t mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic [1:0] count_d;
  logic in_ready_q;
  wire push = in_valid && in_ready_q;
  wire pop = out_valid && out_ready;

  assign count_d = count_q + {1'b0, push} - {1'b0, pop};
  assign in_ready = in_ready_q;
  assign out_valid = (count_q != 2'h0);
  assign out_word = mem_q[rd_ptr_q];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
      in_ready_q <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_d;
      in_ready_q <= (count_d != `BUF_DEPTH);
    end
  end

  // storage needs no reset; valid flags guard it
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_word;
    end
  end

  buf_bound_a: assert property (@(posedge ref_clk) disable iff (reset)
    count_q <= `BUF_DEPTH) else $error("buffer count above depth");
endmodule

// ==== logic/display_serial_host_port.sv ====
`timescale 1ns/1ps
`include "dsp_defines.svh"

module display_serial_host_port (
  input wire logic ref_clk,
  input wire logic reset,
  input wire dsp_pkg::serial_variant_t variant,
  input wire dsp_pkg::timing_cfg_t timing,
  input wire logic preamble_enable,
  input wire logic [3:0] preamble_length,
  input wire logic [15:0] preamble_bits,
  input wire logic rw_first,
  input wire logic rw_disable,
  input wire dsp_pkg::access_cmd_t cmd,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire dsp_pkg::write_word_t wr_word,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic display_chip_select_n,
  output logic serial_shift_clock,
  output logic internal_serial_data_out,
  output logic serial_data_output_enable,
  input wire logic internal_serial_data_in,
  output logic dedicated_register_select_line
);
  // sum kept at ten bits so large settings do not wrap before the divide
  function automatic logic [9:0] ceil_div(input logic [8:0] num, input logic [7:0] den);
    logic [9:0] d;
    logic [9:0] s;
    d = (den == 8'h00) ? 10'h001 : {2'b00, den};
    s = {1'b0, num} + d - 10'h001;
    ceil_div = s / d;
  endfunction

  dsp_pkg::frame_state_t state_q;
  dsp_pkg::frame_state_t state_d;
  dsp_pkg::access_cmd_t cmd_q;
  dsp_pkg::write_word_t head;
  logic [9:0] per_q, up_q, down_q, samp_q, phase_q;
  logic [3:0] idx_q;
  logic [7:0] words_q, word_q, shin_q;
  logic have_word_q;
  logic din_s1_q, din_s2_q;
  logic cs_n_q, sclk_q, dout_q, oe_q, rs_line_q, rd_valid_q, cmd_ready_q;
  logic [7:0] rd_data_q;
  logic head_valid;
  logic load;

  // a stalled write burst holds clock and phase until the buffer delivers
  word_skid_buffer u_buf (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_word(wr_word),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_word(head),
    .out_valid(head_valid),
    .out_ready(load)
  );

  // timing in base half-steps, one per ref_clk cycle; ref_clk is twice the base clock
  wire sel_rd = cmd.read;
  wire [7:0] per_ns = sel_rd ? timing.read_clock_period_setting
                             : timing.write_clock_period_setting;
  wire [7:0] up_ns = sel_rd ? timing.read_clock_rise_setting : timing.write_clock_rise_setting;
  wire [7:0] dn_ns = sel_rd ? timing.read_clock_fall_setting : timing.write_clock_fall_setting;
  wire [7:0] base = timing.base_clock_period_value;
  wire [9:0] per_raw = 10'(ceil_div({1'b0, per_ns}, base) * `BASE_HALF_STEPS);
  wire [9:0] per_calc = (per_raw < `MIN_PERIOD_HALF) ? `MIN_PERIOD_HALF : per_raw;
  wire [9:0] up_calc = ceil_div({up_ns, 1'b0}, base);
  wire [9:0] dn_calc = ceil_div({dn_ns, 1'b0}, base);
  wire [9:0] samp_raw = 10'(ceil_div({1'b0, timing.read_sample_point_setting}, base)
                            * `BASE_HALF_STEPS);
  // clamp short of the last phase so the final bit is shifted before hand-off
  wire [9:0] samp_calc = (samp_raw >= per_calc) ? per_calc - 10'h002 : samp_raw;

  wire idle = (state_q == dsp_pkg::st_idle);
  wire active = (state_q == dsp_pkg::st_pre) || (state_q == dsp_pkg::st_hdr)
                || (state_q == dsp_pkg::st_data);
  wire wr_data = (state_q == dsp_pkg::st_data) && !cmd_q.read;
  wire rd_data_ph = (state_q == dsp_pkg::st_data) && cmd_q.read;
  wire need_word = wr_data && !have_word_q && (idx_q[2:0] == `WORD_MSB);
  assign load = need_word && head_valid;
  wire stall = need_word && !head_valid;
  wire bit_end = (phase_q == per_q - 10'h001) && !stall;
  wire start = idle && cmd_valid && cmd_ready_q;
  wire five_wire = (variant == dsp_pkg::five_wire_clk) || (variant == dsp_pkg::five_wire_cs);
  wire [3:0] hdr_top = rw_disable ? `HDR_ONE_BIT : `HDR_TWO_BITS;
  wire rw_val = cmd_q.read;
  wire hdr_bit = rw_disable ? cmd_q.rs
                 : ((idx_q == `HDR_TWO_BITS) == rw_first) ? rw_val : cmd_q.rs;
  wire [7:0] cur_word = load ? head.data : word_q;
  wire cur_bit = (state_q == dsp_pkg::st_pre) ? preamble_bits[idx_q]
                 : (state_q == dsp_pkg::st_hdr) ? hdr_bit
                 : cur_word[idx_q[2:0]];
  wire sclk_low = active && (phase_q >= up_q) && (phase_q < down_q) && !stall;
  wire sample = rd_data_ph && (phase_q == samp_q);
  wire pre_on = preamble_enable;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dsp_pkg::st_idle: if (start) state_d = pre_on ? dsp_pkg::st_pre : dsp_pkg::st_hdr;
      dsp_pkg::st_pre: if (bit_end && idx_q == `IDX_ZERO) state_d = dsp_pkg::st_hdr;
      dsp_pkg::st_hdr: if (bit_end && idx_q == `IDX_ZERO) state_d = dsp_pkg::st_data;
      dsp_pkg::st_data: begin
        if (bit_end && idx_q == `IDX_ZERO && words_q == `LAST_WORD) begin
          state_d = dsp_pkg::st_gap;
        end
      end
      dsp_pkg::st_gap: if (phase_q == per_q - 10'h001) state_d = dsp_pkg::st_idle;
      default: state_d = dsp_pkg::st_idle;
    endcase
  end

  // second flop only feeds the read shifter; the first is seen by nothing else
  always_ff @(posedge ref_clk) begin
    din_s1_q <= internal_serial_data_in;
    din_s2_q <= din_s1_q;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= dsp_pkg::st_idle;
      cmd_q <= '0;
      per_q <= `MIN_PERIOD_HALF;
      up_q <= `PHASE_ZERO;
      down_q <= `PHASE_ZERO;
      samp_q <= `PHASE_ZERO;
      phase_q <= `PHASE_ZERO;
      idx_q <= `IDX_ZERO;
      words_q <= 8'h00;
      word_q <= 8'h00;
      have_word_q <= 1'b0;
      shin_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (start) begin
        cmd_q <= cmd;
        per_q <= per_calc;
        up_q <= (up_calc > per_calc) ? per_calc : up_calc;
        down_q <= (dn_calc > per_calc) ? per_calc : dn_calc;
        samp_q <= samp_calc;
        phase_q <= `PHASE_ZERO;
        idx_q <= pre_on ? preamble_length : hdr_top;
        words_q <= cmd.words;
        have_word_q <= 1'b0;
      end else if (!idle) begin
        phase_q <= (bit_end || (state_q == dsp_pkg::st_gap && phase_q == per_q - 10'h001))
                   ? `PHASE_ZERO : (stall ? phase_q : phase_q + 10'h001);
        if (load) begin
          word_q <= head.data;
          have_word_q <= 1'b1;
        end
        if (sample) begin
          shin_q <= {shin_q[6:0], din_s2_q};
        end
        if (bit_end) begin
          if (idx_q != `IDX_ZERO) begin
            idx_q <= idx_q - 4'h1;
          end else if (state_q == dsp_pkg::st_pre) begin
            idx_q <= hdr_top;
          end else begin
            idx_q <= {1'b0, `WORD_MSB};
            have_word_q <= 1'b0;
            if (state_q == dsp_pkg::st_data) begin
              words_q <= words_q - 8'h01;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b1;
      dout_q <= 1'b0;
      oe_q <= 1'b0;
      rs_line_q <= 1'b0;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      cmd_ready_q <= 1'b0;
    end else begin
      cs_n_q <= !(start || active) || (bit_end && state_d == dsp_pkg::st_gap);
      sclk_q <= !sclk_low;
      dout_q <= active ? cur_bit : 1'b0;
      oe_q <= (start || active) && !rd_data_ph && !(bit_end && state_d == dsp_pkg::st_data
              && cmd_q.read) && !(bit_end && state_d == dsp_pkg::st_gap);
      // rs line moves only at frame start or a word boundary
      if (start && five_wire) begin
        rs_line_q <= cmd.rs;
      end else if (load && five_wire) begin
        rs_line_q <= head.rs;
      end
      rd_valid_q <= rd_data_ph && bit_end && idx_q == `IDX_ZERO;
      if (rd_data_ph && bit_end && idx_q == `IDX_ZERO) begin
        rd_data_q <= shin_q;
      end
      cmd_ready_q <= (state_d == dsp_pkg::st_idle) && !start;
    end
  end

  assign cmd_ready = cmd_ready_q;
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign display_chip_select_n = cs_n_q;
  assign serial_shift_clock = sclk_q;
  assign internal_serial_data_out = dout_q;
  assign serial_data_output_enable = oe_q;
  assign dedicated_register_select_line = rs_line_q;

  cs_gap_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(cs_n_q) |-> cs_n_q[*2]) else $error("select gap shorter than a period");
  oe_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    $past(rd_data_ph) && rd_data_ph |-> !oe_q) else $error("pin driven during read data");
  idle_cs_a: assert property (@(posedge ref_clk) disable iff (reset)
    $past(idle) && idle |-> cs_n_q) else $error("select active while idle");
  rs_word_a: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(rs_line_q) |-> $past(start) || $past(phase_q) == `PHASE_ZERO)
    else $error("rs line moved inside a word");
  phase_wrap_a: assert property (@(posedge ref_clk) disable iff (reset)
    active && bit_end && state_d != dsp_pkg::st_idle |=> phase_q == `PHASE_ZERO)
    else $error("bit phase did not wrap at period end");
  hdr_order_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(state_q == dsp_pkg::st_data) |-> $past(state_q) == dsp_pkg::st_hdr)
    else $error("data phase entered without header");
  rw_off_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(state_q == dsp_pkg::st_hdr) && rw_disable |-> idx_q == `HDR_ONE_BIT)
    else $error("header too long with rw suppressed");
  rd_word_a: assert property (@(posedge ref_clk) disable iff (reset)
    rd_valid_q |-> rd_data_q == $past(shin_q) && $past(idx_q) == `IDX_ZERO)
    else $error("read word not complete at delivery");
  pre_skip_a: assert property (@(posedge ref_clk) disable iff (reset)
    start && !preamble_enable |=> state_q == dsp_pkg::st_hdr)
    else $error("preamble sent while disabled");
endmodule

// ==== verif/display_model.sv ====
`timescale 1ns/1ps

module display_model (
  input wire logic display_chip_select_n,
  input wire logic serial_shift_clock,
  input wire logic out_line,
  input wire logic serial_data_output_enable,
  input wire logic dedicated_register_select_line,
  input wire logic [4:0] skip,
  input wire logic [7:0] rd_byte,
  output logic drive_data
);
  // one entry per rising clock: {oe, rs line, data}
  logic [2:0] cap[$];
  logic rs_at_cs;
  int n_fall;

  initial begin
    drive_data = 1'b0;
    rs_at_cs = 1'b0;
    n_fall = 0;
  end

  // takes write data and the rs line on the rising clock
  always @(posedge serial_shift_clock) begin
    if (display_chip_select_n === 1'b0) begin
      cap.push_back({serial_data_output_enable, dedicated_register_select_line, out_line});
    end
  end

  // read answer moves on the falling clock, msb first
  always @(negedge serial_shift_clock) begin
    if (display_chip_select_n === 1'b0) begin
      if (n_fall >= skip) begin
        drive_data <= rd_byte[7 - ((n_fall - skip) % 8)];
      end else begin
        drive_data <= ~drive_data;
      end
      n_fall <= n_fall + 1;
    end
  end

  // released line flips so a stale value never looks valid
  always @(posedge display_chip_select_n) begin
    rs_at_cs <= dedicated_register_select_line;
    drive_data <= ~drive_data;
    n_fall <= 0;
  end
endmodule

// ==== verif/display_serial_host_port_tb_top.sv ====
`timescale 1ns/1ps

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module display_serial_host_port_tb_top;
  logic ref_clk, reset, preamble_enable, rw_first, rw_disable;
  logic cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid;
  logic [3:0] preamble_length;
  logic [15:0] preamble_bits;
  logic [7:0] rd_data, rd_byte, rd_seen;
  logic [4:0] skip;
  logic display_chip_select_n, serial_shift_clock, internal_serial_data_out;
  logic serial_data_output_enable, internal_serial_data_in;
  logic dedicated_register_select_line, drive_data, pad;
  dsp_pkg::serial_variant_t variant;
  dsp_pkg::timing_cfg_t timing;
  dsp_pkg::access_cmd_t cmd;
  dsp_pkg::write_word_t wr_word;
  int n_fail, checks, hi_cnt, gap_seen;
  time t_fall, t_prev, t_rise;

  // shared pin joined by the enable in three-wire
  assign pad = serial_data_output_enable ? internal_serial_data_out : drive_data;
  assign internal_serial_data_in = (variant == dsp_pkg::three_wire) ? pad : drive_data;

  display_serial_host_port u_display_serial_host_port (.ref_clk(ref_clk), .reset(reset),
    .variant(variant), .timing(timing), .preamble_enable(preamble_enable),
    .preamble_length(preamble_length), .preamble_bits(preamble_bits), .rw_first(rw_first),
    .rw_disable(rw_disable), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .wr_word(wr_word), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .display_chip_select_n(display_chip_select_n),
    .serial_shift_clock(serial_shift_clock),
    .internal_serial_data_out(internal_serial_data_out),
    .serial_data_output_enable(serial_data_output_enable),
    .internal_serial_data_in(internal_serial_data_in),
    .dedicated_register_select_line(dedicated_register_select_line));

  display_model u_display_model (.display_chip_select_n(display_chip_select_n),
    .serial_shift_clock(serial_shift_clock),
    .out_line((variant == dsp_pkg::three_wire) ? pad : internal_serial_data_out),
    .serial_data_output_enable(serial_data_output_enable),
    .dedicated_register_select_line(dedicated_register_select_line), .skip(skip),
    .rd_byte(rd_byte), .drive_data(drive_data));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(negedge serial_shift_clock) begin
    t_prev = t_fall;
    t_fall = $time;
  end
  always @(posedge serial_shift_clock) t_rise = $time;
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1) rd_seen <= rd_data;
    hi_cnt <= (display_chip_select_n === 1'b1) ? hi_cnt + 1 : 0;
    if (display_chip_select_n === 1'b0 && hi_cnt != 0) gap_seen <= hi_cnt;
  end

  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // holds a request until ready is seen high at an edge
  task automatic send(input logic rd, input logic rs, input logic [7:0] n);
    int i;
    cmd = {rd, rs, n};
    cmd_valid = 1'b1;
    i = 0;
    do begin @(posedge ref_clk); i++; end while (cmd_ready !== 1'b1 && i < 400);
    #1 cmd_valid = 1'b0;
    if (i >= 400) begin n_fail++; tally_and_finish(); end
  endtask

  task automatic push(input logic [8:0] w);
    int i;
    wr_word = w;
    wr_valid = 1'b1;
    i = 0;
    do begin @(posedge ref_clk); i++; end while (wr_ready !== 1'b1 && i < 2000);
    #1 wr_valid = 1'b0;
    if (i >= 2000) begin n_fail++; tally_and_finish(); end
    // let an edge pass so a following call starts clean
    @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_done();
    int i;
    for (i = 0; i < 2000 && display_chip_select_n !== 1'b1; i++) @(posedge ref_clk);
    #1;
    if (i >= 2000) begin n_fail++; tally_and_finish(); end
  endtask

  // dout compared only where the port drives it
  task automatic chk_bits(input int at, input int n, input logic [15:0] v, input logic oe);
    for (int k = 0; k < n; k++) begin
      if (oe) `CHK(u_display_model.cap[at+k][0], v[n-1-k])
      `CHK(u_display_model.cap[at+k][2], oe)
    end
  endtask

  initial begin
    reset = 1'b1;
    variant = dsp_pkg::five_wire_clk;
    timing = {8'h14, 8'ha0, 8'h78, 8'h28, 8'ha0, 8'h78, 8'h28, 8'h8c};
    {preamble_enable, rw_first, rw_disable, cmd_valid, wr_valid} = 5'h08;
    {preamble_length, preamble_bits, cmd, wr_word} = '0;
    {skip, rd_byte, rd_seen, n_fail, checks, hi_cnt, gap_seen} = '0;
    repeat (12) @(posedge ref_clk);
    #1 reset = 1'b0;
    `CHK(display_chip_select_n, 1'b1)
    `CHK(serial_data_output_enable, 1'b0)
    // fill the buffer until it refuses, then drain in a five-wire burst
    push(9'h05a);
    push(9'h1c3);
    `CHK(wr_ready, 1'b0)
    fork
      send(1'b0, 1'b1, 8'h03);
      push(9'h081);
    join
    wait_done();
    `CHK(u_display_model.cap.size(), 26)
    chk_bits(0, 2, 16'h0001, 1'b1);
    chk_bits(2, 8, 16'h005a, 1'b1);
    chk_bits(10, 8, 16'h00c3, 1'b1);
    chk_bits(18, 8, 16'h0081, 1'b1);
    `CHK(u_display_model.cap[1][1], 1'b1)
    for (int b = 0; b < 24; b++) `CHK(u_display_model.cap[2+b][1], b / 8 == 1)
    `CHK(t_fall - t_prev, 160)
    `CHK(t_rise - t_fall, 80)
    // back to back single word, rw bit suppressed
    variant = dsp_pkg::five_wire_cs;
    rw_disable = 1'b1;
    u_display_model.cap.delete();
    send(1'b0, 1'b1, 8'h01);
    // late word: the frame waits with the clock held high
    repeat (40) @(posedge ref_clk);
    #1 push(9'h13c);
    wait_done();
    chk_bits(0, 9, 16'h013c, 1'b1);
    `CHK(gap_seen >= 16, 1'b1)
    `CHK(u_display_model.rs_at_cs, 1'b1)
    // reads with a four-bit preamble, rs before rw
    {rw_first, rw_disable, preamble_enable, preamble_length, preamble_bits} = {3'h1, 4'h3, 16'h000a};
    skip = 5'h06;
    for (int v = 0; v < 2; v++) begin
      variant = v ? dsp_pkg::four_wire : dsp_pkg::three_wire;
      rd_byte = v ? 8'h5a : 8'ha5;
      rd_seen = 8'h00;
      u_display_model.cap.delete();
      send(1'b1, 1'b0, 8'h01);
      wait_done();
      repeat (4) @(posedge ref_clk);
      #1;
      chk_bits(0, 4, 16'h000a, 1'b1);
      chk_bits(4, 2, 16'h0001, 1'b1);
      chk_bits(6, 8, 16'h0000, 1'b0);
      `CHK(rd_seen, rd_byte)
    end
    tally_and_finish();
  end
endmodule
